// *** hw/rat_alarm_tick_control.sv ***
// Summary of operation
// - Seconds counter divides low-speed clock to 1 Hz.
// - Tick disables and alarm enable choose source.
// - Seconds reset request clears counter, reads pending.
// - Alarm preset loads 00:00, day 01, Sunday.
// - 1 Hz interrupt coincides with seconds increment.
// - First tick one second after seconds reset.
// - Run enable low freezes time except for a pending round, counter keeps running.
// - Bank select one routes writes to alarm bank.
// - Interrupt pulse one low-speed cycle, with pin.
// - Time matching alarm pulses pin low, interrupts.
// - Alarm logic steps on low-speed clock ticks.
// - 1 Hz source gives periodic low pin pulse.
`timescale 1ns/1ps
`default_nettype none
`include "rat_map.svh"
module rat_alarm_tick_control #(
	parameter int LS_PER_SEC = `RAT_LS_PER_SEC,
	parameter int LS_PER_16 = `RAT_LS_PER_16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic alarm_pin_n,
	output logic clock_irq_n
);
	logic ls_tick, sec_tick, hz16_tick;
	logic seconds_round_request_pending;
	logic [7:0] t_sec, t_min, t_hour, t_wday, t_date;

	// Control bits.
	logic irq_en_q, irq_en_d, run_en_q, run_en_d, alm_en_q, alm_en_d;
	logic bank_sel_q, bank_sel_d, dis1_q, dis1_d, dis16_q, dis16_d;
	logic srst_q, srst_d;
	logic [2:0] fill_q, fill_d;
	// Alarm bank.
	logic [7:0] a_min_q, a_min_d, a_hour_q, a_hour_d;
	logic [7:0] a_wday_q, a_wday_d, a_date_q, a_date_d;
	// Read path.
	logic [7:0] rdata_q, rdata_d;
	// Event and pin sequencing.
	rat_pkg::rat_pulse_state_t state_q, state_d;
	logic match_prev_q, match_prev_d;
	logic pin_q, pin_d, irq_q, irq_d;

	logic wr_bank, wr_reset, wr_time_ofs, time_wr, alarm_wr;
	logic src_alarm, src_1hz, src_16hz, match, fire;

	// Divider and seconds counter; a pending seconds reset is applied at a low-speed tick.
	rat_ls_divider #(
		.LS_PER_SEC(LS_PER_SEC),
		.LS_PER_16(LS_PER_16)
	) u_div (
		.clock(clock),
		.rst_n(rst_n),
		.sec_clear(srst_q),
		.ls_tick(ls_tick),
		.sec_tick(sec_tick),
		.hz16_tick(hz16_tick)
	);

	// Time-of-day bank, stepped by the 1 Hz tick.
	rat_time_keeper u_time (
		.clock(clock),
		.rst_n(rst_n),
		.sec_tick(sec_tick),
		.run_en(run_en_q),
		.seconds_round_request_set(wr_bank && reg_wdata[`RAT_BK_ADJ]),
		.wr_en(time_wr),
		.wr_field(reg_addr),
		.wr_data(reg_wdata),
		.seconds_round_request_pending(seconds_round_request_pending),
		.sec(t_sec),
		.minute(t_min),
		.hour(t_hour),
		.wday(t_wday),
		.date(t_date)
	);

	// Address decode for writes.
	always_comb begin
		wr_bank = reg_wr && (reg_addr == `RAT_OFS_BANK);
		wr_reset = reg_wr && (reg_addr == `RAT_OFS_RESET);
		wr_time_ofs = (reg_addr == `RAT_OFS_SEC) || (reg_addr == `RAT_OFS_MIN) ||
			(reg_addr == `RAT_OFS_HOUR) || (reg_addr == `RAT_OFS_WDAY) ||
			(reg_addr == `RAT_OFS_DATE);
		time_wr = reg_wr && wr_time_ofs && !bank_sel_q;
		// The alarm bank has no seconds field.
		alarm_wr = reg_wr && wr_time_ofs && bank_sel_q && (reg_addr != `RAT_OFS_SEC);
	end

	// Control and alarm register next values.
	always_comb begin
		irq_en_d = irq_en_q;
		run_en_d = run_en_q;
		alm_en_d = alm_en_q;
		bank_sel_d = bank_sel_q;
		dis1_d = dis1_q;
		dis16_d = dis16_q;
		fill_d = fill_q;
		srst_d = srst_q;
		a_min_d = a_min_q;
		a_hour_d = a_hour_q;
		a_wday_d = a_wday_q;
		a_date_d = a_date_q;
		if (wr_bank) begin
			irq_en_d = reg_wdata[`RAT_BK_IRQEN];
			run_en_d = reg_wdata[`RAT_BK_RUN];
			alm_en_d = reg_wdata[`RAT_BK_ALM];
			bank_sel_d = reg_wdata[`RAT_BK_SEL];
		end
		// The pending reset retires at the low-speed tick that clears the counter.
		if (ls_tick) begin
			srst_d = 1'b0;
		end
		if (wr_reset) begin
			dis1_d = reg_wdata[`RAT_RC_DIS1];
			dis16_d = reg_wdata[`RAT_RC_DIS16];
			fill_d = reg_wdata[`RAT_RC_FILL_MSB:0];
			// A new request wins over retirement in the same cycle; writing zero leaves it.
			if (reg_wdata[`RAT_RC_SRST]) begin
				srst_d = 1'b1;
			end
			if (reg_wdata[`RAT_RC_APRE]) begin
				a_min_d = `RAT_PRE_MIN;
				a_hour_d = `RAT_PRE_HOUR;
				a_date_d = `RAT_PRE_DATE;
				a_wday_d = `RAT_PRE_WDAY;
			end
		end
		if (alarm_wr) begin
			unique case (reg_addr)
				`RAT_OFS_MIN: a_min_d = reg_wdata;
				`RAT_OFS_HOUR: a_hour_d = reg_wdata;
				`RAT_OFS_WDAY: a_wday_d = reg_wdata;
				`RAT_OFS_DATE: a_date_d = reg_wdata;
				default: a_min_d = a_min_d;
			endcase
		end
	end

	// Control and alarm registers.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_q <= 1'b0;
			run_en_q <= 1'b0;
			alm_en_q <= 1'b0;
			bank_sel_q <= 1'b0;
			dis1_q <= 1'b1;
			dis16_q <= 1'b1;
			fill_q <= `RAT_RC_FILL_RST;
			srst_q <= 1'b0;
			a_min_q <= `RAT_PRE_MIN;
			a_hour_q <= `RAT_PRE_HOUR;
			a_wday_q <= `RAT_PRE_WDAY;
			a_date_q <= `RAT_PRE_DATE;
		end else begin
			irq_en_q <= irq_en_d;
			run_en_q <= run_en_d;
			alm_en_q <= alm_en_d;
			bank_sel_q <= bank_sel_d;
			dis1_q <= dis1_d;
			dis16_q <= dis16_d;
			fill_q <= fill_d;
			srst_q <= srst_d;
			a_min_q <= a_min_d;
			a_hour_q <= a_hour_d;
			a_wday_q <= a_wday_d;
			a_date_q <= a_date_d;
		end
	end

	// Read data for the cycle after the strobe; unmapped offsets read zero.
	always_comb begin
		rdata_d = `RAT_ZERO8;
		if (reg_rd) begin
			unique case (reg_addr)
				`RAT_OFS_SEC: rdata_d = bank_sel_q ? `RAT_ZERO8 : t_sec;
				`RAT_OFS_MIN: rdata_d = bank_sel_q ? a_min_q : t_min;
				`RAT_OFS_HOUR: rdata_d = bank_sel_q ? a_hour_q : t_hour;
				`RAT_OFS_WDAY: rdata_d = bank_sel_q ? a_wday_q : t_wday;
				`RAT_OFS_DATE: rdata_d = bank_sel_q ? a_date_q : t_date;
				`RAT_OFS_BANK: rdata_d = {irq_en_q, 2'b00, seconds_round_request_pending, run_en_q,
					alm_en_q, 1'b0, bank_sel_q};
				// Bit 3 and the preset bit read zero; the pending reset reads one.
				`RAT_OFS_RESET: rdata_d = {dis1_q, dis16_q, srst_q, 2'b00, fill_q};
				default: rdata_d = `RAT_ZERO8;
			endcase
		end
	end

	// Read data register.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= `RAT_ZERO8;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Source selection and events. The alarm fires on the first tick of a match, so a match
	// that lasts a whole minute gives one pulse, not sixty.
	always_comb begin
		src_alarm = dis1_q && dis16_q && alm_en_q;
		src_1hz = !dis1_q && dis16_q && !alm_en_q;
		src_16hz = dis1_q && !dis16_q && !alm_en_q;
		match = (t_min == a_min_q) && (t_hour == a_hour_q) && (t_date == a_date_q) &&
			(t_wday == a_wday_q);
		fire = irq_en_q && ((src_alarm && match && !match_prev_q) ||
			(src_1hz && sec_tick) ||
			(src_16hz && hz16_tick));
	end

	// Pin and interrupt sequencer, stepped only on low-speed ticks.
	always_comb begin
		state_d = state_q;
		match_prev_d = match_prev_q;
		pin_d = pin_q;
		irq_d = irq_q;
		if (ls_tick) begin
			match_prev_d = match;
			unique case (state_q)
				rat_pkg::RAT_IDLE: begin
					if (fire) begin
						state_d = rat_pkg::RAT_PULSE;
						pin_d = 1'b0;
						irq_d = 1'b0;
					end
				end
				rat_pkg::RAT_PULSE: begin
					if (!fire) begin
						state_d = rat_pkg::RAT_IDLE;
						pin_d = 1'b1;
						irq_d = 1'b1;
					end
				end
				default: begin
					state_d = rat_pkg::RAT_IDLE;
					pin_d = 1'b1;
					irq_d = 1'b1;
				end
			endcase
		end
	end

	// Sequencer registers; both lines idle high.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= rat_pkg::RAT_IDLE;
			match_prev_q <= 1'b0;
			pin_q <= 1'b1;
			irq_q <= 1'b1;
		end else begin
			state_q <= state_d;
			match_prev_q <= match_prev_d;
			pin_q <= pin_d;
			irq_q <= irq_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign alarm_pin_n = pin_q;
	assign clock_irq_n = irq_q;
endmodule
`default_nettype wire

// *** common/rat_map.svh ***
`ifndef RAT_MAP_SVH
`define RAT_MAP_SVH

// Rates for the low-speed phase accumulator, in Hz.
`define RAT_CLK_HZ 27'h2625a00
`define RAT_LS_HZ 27'h0008000
// Low-speed cycles per second and per sixteenth of a second.
`define RAT_LS_PER_SEC 32768
`define RAT_LS_PER_16 2048

// Register offsets.
`define RAT_OFS_SEC 4'h0
`define RAT_OFS_MIN 4'h1
`define RAT_OFS_HOUR 4'h2
`define RAT_OFS_WDAY 4'h3
`define RAT_OFS_DATE 4'h4
`define RAT_OFS_BANK 4'h7
`define RAT_OFS_RESET 4'h8

// Bank control register fields.
`define RAT_BK_IRQEN 7
`define RAT_BK_ADJ 4
`define RAT_BK_RUN 3
`define RAT_BK_ALM 2
`define RAT_BK_SEL 0

// Counter reset control register fields.
`define RAT_RC_DIS1 7
`define RAT_RC_DIS16 6
`define RAT_RC_SRST 5
`define RAT_RC_APRE 4
`define RAT_RC_FILL_MSB 2
`define RAT_RC_FILL_RST 3'h7

// Alarm preset values and time reset values, BCD.
`define RAT_PRE_MIN 8'h00
`define RAT_PRE_HOUR 8'h00
`define RAT_PRE_DATE 8'h01
`define RAT_PRE_WDAY 8'h00
`define RAT_ZERO8 8'h00

// BCD limits.
`define RAT_SEC_TOP 8'h59
`define RAT_MIN_TOP 8'h59
`define RAT_HOUR_TOP 8'h23
`define RAT_WDAY_TOP 8'h06
`define RAT_DATE_TOP 8'h31
`define RAT_DATE_BASE 8'h01
`define RAT_SEC_HALF 8'h30
`define RAT_BCD_NINE 4'h9

`endif

// *** common/rat_pkg.sv ***
`default_nettype none
package rat_pkg;
	// Alarm pin pulse sequencer states.
	typedef enum logic [1:0] {
		RAT_IDLE = 2'b01,
		RAT_PULSE = 2'b10
	} rat_pulse_state_t;
endpackage
`default_nettype wire

// *** hw/rat_ls_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rat_map.svh"
module rat_ls_divider #(
	parameter int LS_PER_SEC = `RAT_LS_PER_SEC,
	parameter int LS_PER_16 = `RAT_LS_PER_16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sec_clear,
	output logic ls_tick,
	output logic sec_tick,
	output logic hz16_tick
);
	logic [26:0] acc_q;
	logic [26:0] acc_d;
	logic [26:0] sum;
	logic [14:0] sec_cnt_q;
	logic [14:0] sec_cnt_d;
	logic [10:0] sub_cnt_q;
	logic [10:0] sub_cnt_d;

	// A phase accumulator gives the exact average low-speed rate; jitter is one clock.
	always_comb begin
		sum = acc_q + `RAT_LS_HZ;
		ls_tick = (sum >= `RAT_CLK_HZ);
		acc_d = ls_tick ? (sum - `RAT_CLK_HZ) : sum;
	end

	// Seconds counter divides the low-speed rate down to 1 Hz and 16 Hz.
	always_comb begin
		sec_tick = ls_tick && (sec_cnt_q == 15'(LS_PER_SEC - 1));
		hz16_tick = ls_tick && (sub_cnt_q == 11'(LS_PER_16 - 1));
		sec_cnt_d = sec_cnt_q;
		sub_cnt_d = sub_cnt_q;
		if (ls_tick) begin
			if (sec_clear) begin
				sec_cnt_d = '0;
				sub_cnt_d = '0;
			end else begin
				sec_cnt_d = sec_tick ? '0 : sec_cnt_q + 15'h0001;
				sub_cnt_d = (sub_cnt_q == 11'(LS_PER_16 - 1)) ? '0 : sub_cnt_q + 11'h001;
			end
		end
	end

	// State registers.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= '0;
			sec_cnt_q <= '0;
			sub_cnt_q <= '0;
		end else begin
			acc_q <= acc_d;
			sec_cnt_q <= sec_cnt_d;
			sub_cnt_q <= sub_cnt_d;
		end
	end
endmodule
`default_nettype wire

// *** hw/rat_time_keeper.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rat_map.svh"
module rat_time_keeper (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sec_tick,
	input wire logic run_en,
	input wire logic seconds_round_request_set,
	input wire logic wr_en,
	input wire logic [3:0] wr_field,
	input wire logic [7:0] wr_data,
	output logic seconds_round_request_pending,
	output logic [7:0] sec,
	output logic [7:0] minute,
	output logic [7:0] hour,
	output logic [7:0] wday,
	output logic [7:0] date
);
	logic [7:0] sec_q, sec_d, min_q, min_d, hour_q, hour_d;
	logic [7:0] wday_q, wday_d, date_q, date_d;
	logic adj_q, adj_d;
	logic [8:0] s_step, m_step, h_step, w_step, d_step;
	logic min_carry;

	// BCD increment with wrap; the top bit of the result is the carry out.
	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
			input logic [7:0] base);
		logic [8:0] r;
		r = {1'b0, v + 8'h01};
		if (v == top) begin
			r = {1'b1, base};
		end else if (v[3:0] == `RAT_BCD_NINE) begin
			r = {1'b0, v[7:4] + 4'h1, 4'h0};
		end
		return r;
	endfunction

	// Carry chain. Month lengths are not modelled; the date wraps after 31.
	always_comb begin
		s_step = bcd_step(sec_q, `RAT_SEC_TOP, `RAT_ZERO8);
		min_carry = adj_q ? (sec_q >= `RAT_SEC_HALF) : s_step[8];
		m_step = bcd_step(min_q, `RAT_MIN_TOP, `RAT_ZERO8);
		h_step = bcd_step(hour_q, `RAT_HOUR_TOP, `RAT_ZERO8);
		w_step = bcd_step(wday_q, `RAT_WDAY_TOP, `RAT_ZERO8);
		d_step = bcd_step(date_q, `RAT_DATE_TOP, `RAT_DATE_BASE);
		sec_d = sec_q;
		min_d = min_q;
		hour_d = hour_q;
		wday_d = wday_q;
		date_d = date_q;
		adj_d = adj_q;
		// A pending round is applied at the count-up even with the clock stopped.
		if (sec_tick && (run_en || adj_q)) begin
			sec_d = adj_q ? `RAT_ZERO8 : s_step[7:0];
			adj_d = 1'b0;
			if (min_carry) begin
				min_d = m_step[7:0];
				if (m_step[8]) begin
					hour_d = h_step[7:0];
					if (h_step[8]) begin
						wday_d = w_step[7:0];
						date_d = d_step[7:0];
					end
				end
			end
		end
		// A new request wins over completion in the same cycle.
		if (seconds_round_request_set) begin
			adj_d = 1'b1;
		end
		// Software writes override the count, so writes belong after a tick.
		if (wr_en) begin
			unique case (wr_field)
				`RAT_OFS_SEC: sec_d = wr_data;
				`RAT_OFS_MIN: min_d = wr_data;
				`RAT_OFS_HOUR: hour_d = wr_data;
				`RAT_OFS_WDAY: wday_d = wr_data;
				`RAT_OFS_DATE: date_d = wr_data;
				default: sec_d = sec_d;
			endcase
		end
	end

	// Time-of-day registers.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sec_q <= `RAT_ZERO8;
			min_q <= `RAT_ZERO8;
			hour_q <= `RAT_ZERO8;
			wday_q <= `RAT_ZERO8;
			date_q <= `RAT_DATE_BASE;
			adj_q <= 1'b0;
		end else begin
			sec_q <= sec_d;
			min_q <= min_d;
			hour_q <= hour_d;
			wday_q <= wday_d;
			date_q <= date_d;
			adj_q <= adj_d;
		end
	end

	assign seconds_round_request_pending = adj_q;
	assign sec = sec_q;
	assign minute = min_q;
	assign hour = hour_q;
	assign wday = wday_q;
	assign date = date_q;
endmodule
`default_nettype wire

// *** bench/rat_irq_receiver.sv ***
`timescale 1ns/1ps
`default_nettype none
module rat_irq_receiver (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_irq_n,
	output logic [15:0] fall_cnt_q
);
	logic line_q;
	logic [15:0] fall_cnt_d;
	// Only a high-to-low edge is a request, so a line held low raises nothing new.
	always_comb begin
		fall_cnt_d = fall_cnt_q;
		if (line_q && !clock_irq_n) begin
			fall_cnt_d = fall_cnt_q + 16'h0001;
		end
	end
	// The line idles high, so the edge detector starts from high.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= 1'b1;
			fall_cnt_q <= 16'h0000;
		end else begin
			line_q <= clock_irq_n;
			fall_cnt_q <= fall_cnt_d;
		end
	end
endmodule
`default_nettype wire

// *** bench/rat_atc_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module rat_atc_sva #(
	parameter int LS_PER_SEC = 32768,
	parameter int LS_PER_16 = 2048
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic alarm_pin_n,
	input wire logic clock_irq_n
);
	logic [11:0] low_len_q, low_len_d;
	logic [3:0] sel_q, sel_d;
	logic src_ok;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Shadow of irq enable, alarm enable and both tick disables, taken from writes.
	always_comb begin
		sel_d = sel_q;
		low_len_d = alarm_pin_n ? 12'h000 : low_len_q + 12'h001;
		if (reg_wr && reg_addr == 4'h7) begin
			sel_d[3] = reg_wdata[7];
			sel_d[2] = reg_wdata[2];
		end
		if (reg_wr && reg_addr == 4'h8) begin
			sel_d[1:0] = reg_wdata[7:6];
		end
	end
	// The low counter restarts on every high sample, so a stuck pin shows up.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sel_q <= 4'h3;
			low_len_q <= 12'h000;
		end else begin
			sel_q <= sel_d;
			low_len_q <= low_len_d;
		end
	end
	assign src_ok = sel_q[3] && ((sel_q[1:0] == 2'h3 && sel_q[2]) ||
		(!sel_q[2] && (sel_q[1] != sel_q[0])));
	pin_irq_same_a: assert property (alarm_pin_n == clock_irq_n)
		else $error("alarm pin and interrupt line differ");
	pulse_hold_a: assert property ($fell(alarm_pin_n) |=> !alarm_pin_n [*8])
		else $error("pin pulse ended too soon");
	pulse_end_a: assert property ($rose(alarm_pin_n) |->
		low_len_q >= 12'h4c4 && low_len_q <= 12'h4c5)
		else $error("pin pulse not one low-speed period");
	pin_idle_a: assert property (!alarm_pin_n |-> low_len_q < 12'h4c5)
		else $error("pin held low past one period");
	source_gate_a: assert property ($fell(clock_irq_n) |->
		$past(src_ok) || $past(src_ok, 2))
		else $error("interrupt without a valid source");
	reset_reg_fixed_a: assert property (reg_rd && reg_addr == 4'h8 |=>
		reg_rdata[3:0] == 4'h7)
		else $error("reset control low bits wrong");
	bank_readback_a: assert property (reg_wr && reg_addr == 4'h7 ##2 reg_rd &&
		reg_addr == 4'h7 |=> reg_rdata[0] == $past(reg_wdata[0], 3))
		else $error("bank select not read back");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
endmodule
bind rat_alarm_tick_control rat_atc_sva #(.LS_PER_SEC(LS_PER_SEC), .LS_PER_16(LS_PER_16)) chk (
	.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.alarm_pin_n(alarm_pin_n), .clock_irq_n(clock_irq_n));
`default_nettype wire

// *** bench/rat_alarm_tick_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module rat_alarm_tick_control_bench;
	logic clock, rst_n, reg_wr, reg_rd, alarm_pin_n, clock_irq_n;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [15:0] fall_cnt;
	logic [7:0] pre [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
	int n_mismatch, n_tests, n;
	// One second is shortened to 32 low-speed ticks to keep the run short.
	rat_alarm_tick_control #(.LS_PER_SEC(32), .LS_PER_16(2)) uut (.clock(clock),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_pin_n(alarm_pin_n),
		.clock_irq_n(clock_irq_n));
	rat_irq_receiver rx (.clock(clock), .rst_n(rst_n), .clock_irq_n(clock_irq_n),
		.fall_cnt_q(fall_cnt));
	// Free-running 40 MHz clock.
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic summarize();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// A spare cycle after each strobe keeps one assignment per signal per step.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		check(reg_rdata, exp);
		@(posedge clock);
	endtask
	// Waits at most lim cycles for a new falling edge; a missing wanted edge ends the run.
	task automatic wait_fall(input int lim, input bit want, output int cyc);
		logic [15:0] c0;
		c0 = fall_cnt;
		cyc = 0;
		while (fall_cnt == c0 && cyc < lim) begin
			@(posedge clock);
			cyc++;
		end
		if (want && fall_cnt == c0) begin
			n_mismatch++;
			$display("MISMATCH at %0t: no interrupt edge in time", $time);
			summarize();
		end
	endtask
	// Main sequence: reset values, preset, then each interrupt source in turn.
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		n_mismatch = 0;
		n_tests = 0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(4'h8, 8'hc7);
		rd(4'h7, 8'h00);
		wr(4'h7, 8'h01);
		rd(4'h7, 8'h01);
		wr(4'h1, 8'h15);
		rd(4'h1, 8'h15);
		wr(4'h2, 8'h12);
		wr(4'h3, 8'h04);
		wr(4'h4, 8'h21);
		wr(4'h8, 8'hd7);
		for (int i = 0; i < 4; i++) begin
			rd(4'(i + 1), pre[i]);
		end
		rd(4'h8, 8'hc7);
		wr(4'h7, 8'h00);
		rd(4'h1, 8'h00);
		wr(4'h8, 8'h67);
		rd(4'h8, 8'h67);
		wr(4'h7, 8'h08);
		wr(4'h7, 8'h88);
		wait_fall(42000, 1'b1, n);
		check({7'h00, n > 37800 && n < 40300}, 8'h01);
		rd(4'h0, 8'h01);
		// Time is written in the quiet second after the tick, then read back as a matching pair.
		wr(4'h0, 8'h10);
		rd(4'h0, 8'h10);
		rd(4'h0, 8'h10);
		rd(4'h8, 8'h47);
		wr(4'h7, 8'h08);
		wr(4'h8, 8'h87);
		// The round request stays pending, since no further 1 Hz tick falls inside the run.
		wr(4'h7, 8'h98);
		rd(4'h7, 8'h98);
		wait_fall(3000, 1'b1, n);
		wait_fall(3000, 1'b1, n);
		check({7'h00, n > 2430 && n < 2450}, 8'h01);
		// Alarm setup in the safe order, then the time is moved onto the alarm.
		wr(4'h7, 8'h08);
		wr(4'h7, 8'h09);
		wr(4'h8, 8'hd7);
		wr(4'h1, 8'h05);
		wr(4'h7, 8'h0d);
		wr(4'h7, 8'h8d);
		wr(4'h7, 8'h8c);
		// The last 16 Hz pulse must end first, or a match at its closing tick would stretch it.
		repeat (1300) @(posedge clock);
		check({7'h00, alarm_pin_n}, 8'h01);
		wr(4'h1, 8'h05);
		wait_fall(1300, 1'b1, n);
		check({7'h00, n < 1225}, 8'h01);
		check({7'h00, alarm_pin_n}, 8'h00);
		check({7'h00, clock_irq_n}, 8'h00);
		// The handler programs the next alarm before it returns.
		wr(4'h7, 8'h8d);
		wr(4'h1, 8'h06);
		rd(4'h1, 8'h06);
		wr(4'h7, 8'h0c);
		wr(4'h7, 8'h08);
		wr(4'h8, 8'h07);
		wr(4'h7, 8'h88);
		wait_fall(3000, 1'b0, n);
		check({7'h00, n == 3000}, 8'h01);
		summarize();
	end
endmodule
`default_nettype wire
